// ### core/sbp_pkg.sv
// Purpose: shared constants, types and helpers of the serial bus datapath
// Assumes: i_clk is the internal high-speed reference once the PLL runs
// Notes:   speed codes 0..2 stand for S100, S200 and S400
package sbp_pkg;
  localparam int N_PORTS         = 6;
  localparam int WORD_W          = 8;
  localparam int XTAL_KHZ        = 24576;
  localparam int REF_KHZ         = 393216;
  localparam int SYS_KHZ         = 49152;
  localparam int S100_KBPS       = 98304;
  localparam int S200_KBPS       = 196608;
  localparam int S400_KBPS       = 393216;
  localparam int PLL_MULT        = REF_KHZ / XTAL_KHZ;
  localparam int SYS_DIV         = REF_KHZ / SYS_KHZ;
  localparam int LOCK_XTAL_EDGES = 64;
  localparam int XTAL_LOSS_CYC   = 2 * PLL_MULT;
  localparam int RX_IDLE_CYC     = 16;

  localparam logic [1:0] SPD_S100 = 2'h0;
  localparam logic [1:0] SPD_S200 = 2'h1;
  localparam logic [1:0] SPD_S400 = 2'h2;

  localparam logic [1:0] LS_ZERO = 2'h0;
  localparam logic [1:0] LS_ONE  = 2'h1;
  localparam logic [1:0] LS_Z    = 2'h2;

  typedef enum logic [1:0] {PLL_OFF, PLL_LOCK, PLL_RUN} sbp_pll_t;
  typedef enum logic [1:0] {LNK_IDLE, LNK_TX, LNK_RX} sbp_link_t;

  function automatic logic [2:0] cyc_per_bit(input logic [1:0] spd);
    case (spd)
      SPD_S400: cyc_per_bit = 3'(REF_KHZ / S400_KBPS);
      SPD_S200: cyc_per_bit = 3'(REF_KHZ / S200_KBPS);
      default:  cyc_per_bit = 3'(REF_KHZ / S100_KBPS);
    endcase
  endfunction

  function automatic logic [3:0] bits_per_word(input logic [1:0] spd);
    bits_per_word = 4'(SYS_DIV / int'(cyc_per_bit(spd)));
  endfunction

  // cm = {above S400 level, above S200 level}
  function automatic logic [1:0] cm_speed(input logic [1:0] cm);
    cm_speed = cm[1] ? SPD_S400 : (cm[0] ? SPD_S200 : SPD_S100);
  endfunction

  // cmp = {plus above minus, minus above plus}
  function automatic logic [1:0] line_state(input logic [1:0] cmp);
    line_state = cmp[1] ? LS_ONE : (cmp[0] ? LS_ZERO : LS_Z);
  endfunction
endpackage

// ### core/sbp_ser.sv
// Purpose: parallel-to-serial shifter with data-strobe encoder
// Assumes: a new word is loaded every system tick while sending
// Notes:   lane 0 leaves first; repeat bits bypass the shifter
`timescale 1ns/100ps
module sbp_ser (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_load,
  input  wire logic [7:0] i_word,
  input  wire logic [1:0] i_speed,
  input  wire logic       i_rep_sel,
  input  wire logic       i_rep_bit,
  input  wire logic       i_rep_valid,
  output logic            o_data,
  output logic            o_strobe,
  output logic            o_busy
);
  logic [7:0] shreg;
  logic [3:0] left;
  logic [2:0] div;
  logic [1:0] spd;
  logic       tx_fire;
  logic       fire;
  logic       bit_now;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shreg <= 8'h00;
      left  <= 4'h0;
      div   <= 3'h0;
      spd   <= sbp_pkg::SPD_S100;
    end else if (i_load) begin
      shreg <= i_word;
      left  <= sbp_pkg::bits_per_word(i_speed);
      div   <= 3'h0;
      spd   <= i_speed;
    end else if (left != 4'h0) begin
      if (div == sbp_pkg::cyc_per_bit(spd) - 3'h1) begin
        div   <= 3'h0;
        shreg <= shreg >> 1;
        left  <= left - 4'h1;
      end else begin
        div <= div + 3'h1;
      end
    end
  end

  assign tx_fire = (left != 4'h0) && (div == 3'h0);
  assign fire    = i_rep_sel ? i_rep_valid : tx_fire;
  assign bit_now = i_rep_sel ? i_rep_bit : shreg[0];
  assign o_busy  = left != 4'h0;

  // exactly one of data and strobe changes per bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_data   <= 1'b0;
      o_strobe <= 1'b0;
    end else if (fire) begin
      o_data <= bit_now;
      if (bit_now == o_data) begin
        o_strobe <= ~o_strobe;
      end
    end
  end
endmodule

// ### core/sbp_des.sv
// Purpose: data-strobe decoder and serial-to-parallel gatherer
// Assumes: inputs already pass through two flip-flops
// Notes:   first bit lands in lane 0; narrow words read zero above
`timescale 1ns/100ps
module sbp_des (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_enable,
  input  wire logic       i_data,
  input  wire logic       i_strobe,
  input  wire logic [1:0] i_speed,
  output logic [7:0]      o_word,
  output logic            o_word_valid,
  output logic            o_bit,
  output logic            o_bit_valid
);
  logic       prev_par;
  logic [2:0] idx;
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic       fire;

  // a parity change of data and strobe is the recovered clock edge
  assign fire        = i_enable && ((i_data ^ i_strobe) != prev_par);
  assign o_bit       = i_data;
  assign o_bit_valid = fire;

  always_comb begin
    next_acc      = acc;
    next_acc[idx] = i_data;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_par <= 1'b0;
    end else begin
      prev_par <= i_data ^ i_strobe;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_enable) begin
      idx          <= 3'h0;
      acc          <= 8'h00;
      o_word       <= 8'h00;
      o_word_valid <= 1'b0;
    end else begin
      o_word_valid <= 1'b0;
      if (fire) begin
        if ({1'b0, idx} + 4'h1 == sbp_pkg::bits_per_word(i_speed)) begin
          o_word       <= next_acc;
          o_word_valid <= 1'b1;
          idx          <= 3'h0;
          acc          <= 8'h00;
        end else begin
          acc <= next_acc;
          idx <= idx + 3'h1;
        end
      end
    end
  end
endmodule

// ### core/sbp_phy.sv
// Purpose: cable node datapath: clocking, line coding, repeat, resync
// Assumes: i_clk stands for the high-speed reference while the PLL runs
// Notes:   controller-side inputs are synchronous to o_sysclk
`timescale 1ns/100ps
module sbp_phy #(
  parameter int NP = sbp_pkg::N_PORTS
) (
  input  wire logic [2*NP-1:0] i_twisted_pair_a_cm,
  input  wire logic [2*NP-1:0] i_twisted_pair_a_cmp,
  input  wire logic [2*NP-1:0] i_twisted_pair_b_cmp,
  input  wire logic [NP-1:0]   i_twisted_pair_a_rx,
  input  wire logic [NP-1:0]   i_twisted_pair_b_rx,
  input  wire logic [NP-1:0]   i_twisted_pair_b_bias,
  input  wire logic [NP-1:0]   i_port_disable,
  input  wire logic [7:0]      i_tx_data,
  input  wire logic [1:0]      i_tx_speed,
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_xtal,
  input  wire logic            i_power_down_pin,
  input  wire logic            i_iso,
  input  wire logic            i_tx_req,
  input  wire logic            i_arb_phase,
  output logic [4*NP-1:0]      o_arb_status,
  output logic [NP-1:0]        o_twisted_pair_a_tx,
  output logic [NP-1:0]        o_twisted_pair_a_oe,
  output logic [NP-1:0]        o_twisted_pair_b_tx,
  output logic [NP-1:0]        o_twisted_pair_b_oe,
  output logic [NP-1:0]        o_rx_enable,
  output logic [NP-1:0]        o_port_termination_bias_en,
  output logic [NP-1:0]        o_connected,
  output logic [7:0]           o_rx_data,
  output logic [1:0]           o_rx_speed,
  output logic                 o_rx_valid,
  output logic                 o_sysclk,
  output logic                 o_pll_run,
  output logic                 o_tx_busy,
  output logic                 o_rx_active
);
  localparam int DIV_W = $clog2(sbp_pkg::SYS_DIV);
  localparam int SEL_W = $clog2(NP);

  logic [1:0]        pd_s;
  logic [1:0]        iso_s;
  logic [2:0]        xt_s;
  logic [NP-1:0]     a_s1;
  logic [NP-1:0]     a_s2;
  logic [NP-1:0]     b_s1;
  logic [NP-1:0]     b_s2;
  logic [NP-1:0]     bias_s1;
  logic [NP-1:0]     bias_s2;
  logic [2*NP-1:0]   acmp_s1;
  logic [2*NP-1:0]   acmp_s2;
  logic [2*NP-1:0]   bcmp_s1;
  logic [2*NP-1:0]   bcmp_s2;
  logic [2*NP-1:0]   cm_s1;
  logic [2*NP-1:0]   cm_s2;
  logic              pd;
  logic              xt_edge;
  logic              ref_run;
  sbp_pkg::sbp_pll_t pll_st;
  logic [6:0]        lock_cnt;
  logic [5:0]        loss_cnt;
  logic [DIV_W-1:0]  div_cnt;
  logic              sys_tick;
  logic [NP-1:0]     par_prev;
  logic [NP-1:0]     act;
  logic [NP-1:0]     conn;
  logic [1:0]        port_spd [NP];
  sbp_pkg::sbp_link_t link_st;
  logic [SEL_W-1:0]  rx_port;
  logic [SEL_W-1:0]  next_port;
  logic [SEL_W-1:0]  sel_port;
  logic              rx_found;
  logic              go_rx;
  logic              go_tx;
  logic              rx_en;
  logic              tx_load;
  logic [4:0]        idle_cnt;
  logic              ser_busy;
  logic              enc_d;
  logic              enc_s;
  logic [7:0]        rx_word;
  logic              rx_word_valid;
  logic              rx_bit;
  logic              rx_bit_valid;
  logic [1:0]        sel_spd;
  logic [7:0]        rx_hold;
  logic              rx_pend;
  logic [10:0]       ctl_lvl;
  logic [10:0]       ctl_prev;
  logic [NP-1:0]     tx_on;

  // two-stage capture of the line, power-down and iso inputs, three stages for i_xtal; i_port_disable and the controller inputs are used directly
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pd_s    <= 2'h0;
      iso_s   <= 2'h0;
      xt_s    <= 3'h0;
      a_s1    <= '0;
      a_s2    <= '0;
      b_s1    <= '0;
      b_s2    <= '0;
      bias_s1 <= '0;
      bias_s2 <= '0;
      acmp_s1 <= '0;
      acmp_s2 <= '0;
      bcmp_s1 <= '0;
      bcmp_s2 <= '0;
      cm_s1   <= '0;
      cm_s2   <= '0;
    end else begin
      pd_s    <= {pd_s[0], i_power_down_pin};
      iso_s   <= {iso_s[0], i_iso};
      xt_s    <= {xt_s[1:0], i_xtal};
      a_s1    <= i_twisted_pair_a_rx;
      a_s2    <= a_s1;
      b_s1    <= i_twisted_pair_b_rx;
      b_s2    <= b_s1;
      bias_s1 <= i_twisted_pair_b_bias;
      bias_s2 <= bias_s1;
      acmp_s1 <= i_twisted_pair_a_cmp;
      acmp_s2 <= acmp_s1;
      bcmp_s1 <= i_twisted_pair_b_cmp;
      bcmp_s2 <= bcmp_s1;
      cm_s1   <= i_twisted_pair_a_cm;
      cm_s2   <= cm_s1;
    end
  end

  assign pd      = pd_s[1];
  assign xt_edge = xt_s[2] ^ xt_s[1];
  assign ref_run = pll_st == sbp_pkg::PLL_RUN;

  // crystal activity watchdog
  always_ff @(posedge i_clk) begin
    if (i_rst || xt_edge) begin
      loss_cnt <= 6'h00;
    end else if (loss_cnt != 6'(sbp_pkg::XTAL_LOSS_CYC - 1)) begin
      loss_cnt <= loss_cnt + 6'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pll_st   <= sbp_pkg::PLL_OFF;
      lock_cnt <= 7'h00;
    end else begin
      case (pll_st)
        sbp_pkg::PLL_OFF: begin
          lock_cnt <= 7'h00;
          if (!pd) begin
            pll_st <= sbp_pkg::PLL_LOCK;
          end
        end
        sbp_pkg::PLL_LOCK: begin
          if (pd) begin
            pll_st <= sbp_pkg::PLL_OFF;
          end else if (xt_edge) begin
            if (lock_cnt == 7'(sbp_pkg::LOCK_XTAL_EDGES - 1)) begin
              pll_st <= sbp_pkg::PLL_RUN;
            end
            lock_cnt <= lock_cnt + 7'h01;
          end
        end
        sbp_pkg::PLL_RUN: begin
          if (pd) begin
            pll_st <= sbp_pkg::PLL_OFF;
          end else if (loss_cnt == 6'(sbp_pkg::XTAL_LOSS_CYC - 1)) begin
            pll_st   <= sbp_pkg::PLL_LOCK;
            lock_cnt <= 7'h00;
          end
        end
        default: pll_st <= sbp_pkg::PLL_OFF;
      endcase
    end
  end

  // reference divided down to the system clock
  always_ff @(posedge i_clk) begin
    if (i_rst || !ref_run) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  assign sys_tick = ref_run && (div_cnt == DIV_W'(sbp_pkg::SYS_DIV - 1));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sysclk  <= 1'b0;
      o_pll_run <= 1'b0;
    end else begin
      o_sysclk  <= ref_run & div_cnt[DIV_W-1];
      o_pll_run <= ref_run;
    end
  end

  assign conn = bias_s2 & ~i_port_disable;
  assign act  = (a_s2 ^ b_s2) ^ par_prev;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      par_prev <= '0;
    end else begin
      par_prev <= a_s2 ^ b_s2;
    end
  end

  // speed of the next packet per port, caught while arbitrating
  always_ff @(posedge i_clk) begin
    for (int p = 0; p < NP; p++) begin
      if (i_rst) begin
        port_spd[p] <= sbp_pkg::SPD_S100;
      end else if (i_arb_phase) begin
        port_spd[p] <= sbp_pkg::cm_speed(cm_s2[2*p +: 2]);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_arb_status <= '0;
    end else if (link_st == sbp_pkg::LNK_IDLE) begin
      for (int p = 0; p < NP; p++) begin
        o_arb_status[4*p +: 4] <= {sbp_pkg::line_state(acmp_s2[2*p +: 2]),
                                   sbp_pkg::line_state(bcmp_s2[2*p +: 2])};
      end
    end
  end

  // lowest connected port showing a line transition
  always_comb begin
    next_port = '0;
    rx_found  = 1'b0;
    for (int p = NP - 1; p >= 0; p--) begin
      if (act[p] && conn[p]) begin
        next_port = SEL_W'(p);
        rx_found  = 1'b1;
      end
    end
  end

  assign go_rx    = (link_st == sbp_pkg::LNK_IDLE) && ref_run && !i_arb_phase && rx_found;
  assign go_tx    = (link_st == sbp_pkg::LNK_IDLE) && ref_run && !i_arb_phase && !rx_found
                    && i_tx_req && sys_tick;
  assign rx_en    = go_rx || (link_st == sbp_pkg::LNK_RX);
  assign sel_port = (link_st == sbp_pkg::LNK_RX) ? rx_port : next_port;
  assign sel_spd  = port_spd[sel_port];
  assign tx_load  = go_tx || ((link_st == sbp_pkg::LNK_TX) && sys_tick && i_tx_req);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      link_st <= sbp_pkg::LNK_IDLE;
      rx_port <= '0;
    end else begin
      case (link_st)
        sbp_pkg::LNK_IDLE: begin
          if (go_rx) begin
            link_st <= sbp_pkg::LNK_RX;
            rx_port <= next_port;
          end else if (go_tx) begin
            link_st <= sbp_pkg::LNK_TX;
          end
        end
        sbp_pkg::LNK_TX: begin
          if (!ref_run || (sys_tick && !i_tx_req && !ser_busy)) begin
            link_st <= sbp_pkg::LNK_IDLE;
          end
        end
        sbp_pkg::LNK_RX: begin
          if (!ref_run || idle_cnt == 5'(sbp_pkg::RX_IDLE_CYC - 1)) begin
            link_st <= sbp_pkg::LNK_IDLE;
          end
        end
        default: link_st <= sbp_pkg::LNK_IDLE;
      endcase
    end
  end

  // packet ends after a quiet spell on the receiving port
  always_ff @(posedge i_clk) begin
    if (i_rst || link_st != sbp_pkg::LNK_RX || rx_bit_valid) begin
      idle_cnt <= 5'h00;
    end else begin
      idle_cnt <= idle_cnt + 5'h01;
    end
  end

  sbp_ser u_ser (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_load      (tx_load),
    .i_word      (i_tx_data),
    .i_speed     (i_tx_speed),
    .i_rep_sel   (rx_en),
    .i_rep_bit   (rx_bit),
    .i_rep_valid (rx_bit_valid),
    .o_data      (enc_d),
    .o_strobe    (enc_s),
    .o_busy      (ser_busy)
  );

  sbp_des u_des (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_enable     (rx_en),
    .i_data       (a_s2[sel_port]),
    .i_strobe     (b_s2[sel_port]),
    .i_speed      (sel_spd),
    .o_word       (rx_word),
    .o_word_valid (rx_word_valid),
    .o_bit        (rx_bit),
    .o_bit_valid  (rx_bit_valid)
  );

  // word held until the next system tick; a new word wins over the clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_hold <= 8'h00;
      rx_pend <= 1'b0;
    end else if (rx_word_valid) begin
      rx_hold <= rx_word;
      rx_pend <= 1'b1;
    end else if (sys_tick) begin
      rx_pend <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl_lvl <= 11'h000;
    end else if (sys_tick) begin
      ctl_lvl <= {rx_pend, rx_hold, sel_spd};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl_prev   <= 11'h000;
      o_rx_valid <= 1'b0;
      o_rx_data  <= 8'h00;
      o_rx_speed <= 2'h0;
    end else begin
      ctl_prev <= ctl_lvl;
      if (iso_s[1]) begin
        {o_rx_valid, o_rx_data, o_rx_speed} <= ctl_lvl;
      end else begin
        {o_rx_valid, o_rx_data, o_rx_speed} <= ctl_lvl ^ ctl_prev;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      tx_on[p] = ref_run && !pd && conn[p] && ((link_st == sbp_pkg::LNK_TX)
                 || (rx_en && SEL_W'(p) != sel_port));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_twisted_pair_a_tx <= '0;
      o_twisted_pair_a_oe <= '0;
      o_twisted_pair_b_tx <= '0;
      o_twisted_pair_b_oe <= '0;
      o_rx_enable         <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        o_twisted_pair_a_tx[p] <= tx_on[p] & enc_s;
        o_twisted_pair_b_tx[p] <= tx_on[p] & enc_d;
        o_twisted_pair_a_oe[p] <= tx_on[p];
        o_twisted_pair_b_oe[p] <= tx_on[p];
        o_rx_enable[p]         <= rx_en && SEL_W'(p) == sel_port;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_port_termination_bias_en <= '0;
      o_connected                <= '0;
      o_tx_busy                  <= 1'b0;
      o_rx_active                <= 1'b0;
    end else begin
      o_port_termination_bias_en <= {NP{!pd}} & ~i_port_disable;
      o_connected                <= conn;
      o_tx_busy                  <= link_st == sbp_pkg::LNK_TX;
      o_rx_active                <= link_st == sbp_pkg::LNK_RX;
    end
  end
endmodule

// ### tb/sbp_phy_checker.sv
// Purpose: port-level checks of the cable node datapath
// Assumes: bound onto sbp_phy, one clock domain
// Notes:   reset is synchronous, active high
`timescale 1ns/100ps
module sbp_phy_checker #(
  parameter int NP = 6
) (
  input wire logic          i_clk,
  input wire logic          i_rst,
  input wire logic          i_power_down_pin,
  input wire logic          i_tx_req,
  input wire logic          i_arb_phase,
  input wire logic [NP-1:0] i_port_disable,
  input wire logic [NP-1:0] i_twisted_pair_b_bias,
  input wire logic [NP-1:0] o_twisted_pair_a_tx,
  input wire logic [NP-1:0] o_twisted_pair_a_oe,
  input wire logic [NP-1:0] o_twisted_pair_b_tx,
  input wire logic [NP-1:0] o_twisted_pair_b_oe,
  input wire logic [NP-1:0] o_rx_enable,
  input wire logic [NP-1:0] o_port_termination_bias_en,
  input wire logic [NP-1:0] o_connected,
  input wire logic          o_sysclk,
  input wire logic          o_pll_run,
  input wire logic          o_tx_busy,
  input wire logic          o_rx_active,
  input wire logic          o_rx_valid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_pd_stops_pll: assert property (i_power_down_pin [*6] |-> !o_pll_run && !o_sysclk)
    else $error("pll runs in power-down");
  a_bias_enable: assert property (
    ($stable(i_power_down_pin) && $stable(i_port_disable)) [*4]
    |-> o_port_termination_bias_en == (i_power_down_pin ? {NP{1'b0}} : ~i_port_disable))
    else $error("bias enable wrong");
  a_sysclk_shape: assert property (disable iff (i_rst || i_power_down_pin)
    $rose(o_sysclk) |-> o_sysclk [*4] ##1 !o_sysclk [*4])
    else $error("system clock not four high four low");
  a_ds_one_edge: assert property (((o_twisted_pair_a_tx ^ $past(o_twisted_pair_a_tx))
    & (o_twisted_pair_b_tx ^ $past(o_twisted_pair_b_tx)) & o_twisted_pair_b_oe
    & $past(o_twisted_pair_b_oe)) == '0)
    else $error("data and strobe change together");
  a_pairs_together: assert property (o_twisted_pair_a_oe == o_twisted_pair_b_oe)
    else $error("pair enables differ");
  a_rx_port_quiet: assert property ($onehot0(o_rx_enable)
    && (o_rx_enable & o_twisted_pair_b_oe) == '0)
    else $error("receiving port drives");
  a_link_exclusive: assert property (!(o_tx_busy && o_rx_active))
    else $error("send and receive together");
  a_tx_needs_req: assert property (
    $rose(o_tx_busy) |-> $past(i_tx_req) && !$past(i_arb_phase))
    else $error("send started without request");
  a_oe_connected: assert property ((o_twisted_pair_b_oe & ~o_connected) == '0)
    else $error("drive on unconnected port");
  a_connected: assert property (
    ($stable(i_twisted_pair_b_bias) && $stable(i_port_disable)) [*4]
    |-> o_connected == (i_twisted_pair_b_bias & ~i_port_disable))
    else $error("connection flags wrong");

  c_tx: cover property ($rose(o_tx_busy));
  c_rx: cover property ($rose(o_rx_active));
  c_valid: cover property ($rose(o_rx_valid));
  c_repeat: cover property (o_rx_active && o_twisted_pair_b_oe != '0);
endmodule

// ### tb/sbp_remote_node.sv
// Purpose: remote cable node sending data-strobe bits into one port
// Assumes: line levels are held between frames
// Notes:   i_cpb sets cycles per bit, larger values answer slowly
`timescale 1ns/100ps
module sbp_remote_node (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic [7:0] i_byte,
  input  wire logic [3:0] i_nbits,
  input  wire logic [2:0] i_cpb,
  output logic            o_data,
  output logic            o_strobe
);
  logic [7:0] sh = 8'h00;
  logic [3:0] left = 4'h0;
  logic [2:0] cnt = 3'h0;
  initial begin
    o_data = 1'b0;
    o_strobe = 1'b0;
  end
  always @(posedge i_clk) begin
    if (left == 4'h0 && i_start) begin
      sh = i_byte;
      left = i_nbits;
      cnt = 3'h0;
    end
    if (left != 4'h0 && cnt == 3'h0) begin
      if (sh[0] == o_data) o_strobe <= ~o_strobe;
      else o_data <= sh[0];
      sh = sh >> 1;
      left = left - 4'h1;
      cnt = i_cpb - 3'h1;
    end else if (cnt != 3'h0) begin
      cnt = cnt - 3'h1;
    end
  end
endmodule

// ### tb/test_six_port_serial_bus_phy_datapath.sv
// Purpose: self-checking bench for the cable node datapath
// Assumes: ports 0 to 2 see remote bias, port 2 is disabled
// Notes:   remote node feeds port 0 at S400
`timescale 1ns/100ps
bind sbp_phy sbp_phy_checker #(.NP(NP)) u_chk (.*);
module test_six_port_serial_bus_phy_datapath;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_xtal = 1'b0;
  logic        i_power_down_pin = 1'b0;
  logic        i_iso = 1'b1;
  logic        i_tx_req = 1'b0;
  logic        i_arb_phase = 1'b0;
  logic [7:0]  i_tx_data = 8'h00;
  logic [1:0]  i_tx_speed = 2'h0;
  logic [11:0] i_twisted_pair_a_cm = 12'h000;
  logic [11:0] i_twisted_pair_a_cmp = 12'h000;
  logic [11:0] i_twisted_pair_b_cmp = 12'h000;
  logic [5:0]  i_twisted_pair_a_rx, i_twisted_pair_b_rx;
  logic [5:0]  i_twisted_pair_b_bias = 6'h00;
  logic [5:0]  i_port_disable = 6'h04;
  logic [23:0] o_arb_status;
  logic [5:0]  o_twisted_pair_a_tx, o_twisted_pair_a_oe, o_twisted_pair_b_tx;
  logic [5:0]  o_twisted_pair_b_oe, o_rx_enable, o_port_termination_bias_en, o_connected;
  logic [7:0]  o_rx_data;
  logic [1:0]  o_rx_speed;
  logic        o_rx_valid, o_sysclk, o_pll_run, o_tx_busy, o_rx_active;
  logic        rm_start = 1'b0;
  logic        rm_d, rm_s;
  logic [7:0]  rm_byte = 8'h00;
  logic [1:0]  xdiv = 2'h0;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  assign i_twisted_pair_a_rx = {5'h00, rm_d};
  assign i_twisted_pair_b_rx = {5'h00, rm_s};
  sbp_phy dut (.*);
  sbp_remote_node u_remote (.i_clk(i_clk), .i_start(rm_start), .i_byte(rm_byte),
    .i_nbits(4'h8), .i_cpb(3'h1), .o_data(rm_d), .o_strobe(rm_s));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (!ok) begin
      err_count++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask
  task automatic stop_test;
    $display("counts: checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // crystal edge every 3 cycles, plus hang guard
  always @(posedge i_clk) begin
    #2;
    xdiv = (xdiv == 2'h2) ? 2'h0 : xdiv + 2'h1;
    if (xdiv == 2'h0) i_xtal = ~i_xtal;
    cycles++;
    if (cycles == 6000) begin
      chk(1'b0, "timeout");
      stop_test();
    end
  end
  task automatic t_start;
    int n;
    int highs;
    for (n = 0; n < 1000 && o_pll_run !== 1'b1; n++) step(1);
    chk(o_pll_run === 1'b1, "pll never runs");
    highs = 0;
    for (n = 0; n < 80; n++) begin
      step(1);
      if (o_sysclk === 1'b1) highs++;
    end
    chk(highs == 40, "system clock not ref/8");
    chk(o_port_termination_bias_en === 6'h3b, "bias enables");
    i_twisted_pair_b_bias = 6'h07;
    step(5);
    chk(o_connected === 6'h03, "connected flags");
    $display("test start done");
  endtask
  task automatic t_arb;
    logic [23:0] exp;
    exp = {{8{sbp_pkg::LS_Z}}, sbp_pkg::LS_ZERO, sbp_pkg::LS_ONE, sbp_pkg::LS_ONE,
      sbp_pkg::LS_ZERO};
    i_twisted_pair_a_cm = 12'h002;
    i_twisted_pair_a_cmp = 12'h006;
    i_twisted_pair_b_cmp = 12'h009;
    i_arb_phase = 1'b1;
    step(6);
    chk(o_arb_status === exp, "line states");
    i_arb_phase = 1'b0;
    step(2);
    $display("test arb done");
  endtask
  task automatic t_tx(input logic [1:0] spd, input logic [7:0] data);
    int n;
    logic pp;
    logic par;
    i_tx_data = data;
    i_tx_speed = spd;
    i_tx_req = 1'b1;
    for (n = 0; n < 12 && o_tx_busy !== 1'b1; n++) step(1);
    i_tx_req = 1'b0;
    chk(o_tx_busy === 1'b1, "send not taken");
    for (n = 0; n < 12 && o_twisted_pair_b_oe[1] !== 1'b1; n++) step(1);
    chk(o_twisted_pair_a_oe[1:0] === 2'h3, "pairs not driven");
    // first encoded bit reaches the pair registers one edge after the enable
    step(1);
    for (n = 0; n < (2 << spd); n++) begin
      chk(o_twisted_pair_b_tx[1] === data[n], "pair b data bit");
      par = o_twisted_pair_b_tx[1] ^ o_twisted_pair_a_tx[1];
      if (n > 0) chk((par ^ pp) === 1'b1, "ds");
      pp = par;
      step(4 >> spd);
    end
    for (n = 0; n < 30 && o_tx_busy !== 1'b0; n++) step(1);
    chk(o_tx_busy === 1'b0, "send did not end");
    $display("test tx speed %0d done", spd);
  endtask
  task automatic t_rx(input logic [7:0] b);
    int n;
    rm_byte = b;
    rm_start = 1'b1;
    step(1);
    rm_start = 1'b0;
    for (n = 0; n < 10 && o_rx_active !== 1'b1; n++) step(1);
    chk(o_rx_enable === 6'h01, "port 0 receiver");
    step(3);
    chk(o_twisted_pair_b_oe[1:0] === 2'h2, "repeat ports");
    for (n = 0; n < 40 && o_rx_valid !== 1'b1; n++) step(1);
    if (i_iso === 1'b1) begin
      chk(o_rx_data === b, "received word");
      chk(o_rx_speed === sbp_pkg::SPD_S400, "receive speed");
    end else begin
      chk(o_rx_data === (b ^ 8'h3a), "edge word");
    end
    step(1);
    chk(o_rx_valid === i_iso, "valid form");
    for (n = 0; n < 60 && o_rx_active !== 1'b0; n++) step(1);
    $display("test rx %0h done", b);
  endtask
  task automatic t_pd;
    int n;
    i_power_down_pin = 1'b1;
    step(8);
    chk(o_pll_run === 1'b0, "pll runs");
    for (n = 0; n < 16; n++) begin
      chk(o_sysclk === 1'b0, "clock in power-down");
      step(1);
    end
    chk(o_port_termination_bias_en === 6'h00, "bias in power-down");
    i_power_down_pin = 1'b0;
    for (n = 0; n < 1000 && o_pll_run !== 1'b1; n++) step(1);
    chk(o_pll_run === 1'b1, "pll no restart");
    $display("test pd done");
  endtask
  initial begin
    step(8);
    i_rst = 1'b0;
    t_start();
    t_arb();
    t_tx(sbp_pkg::SPD_S400, 8'ha5);
    t_tx(sbp_pkg::SPD_S200, 8'hf9);
    t_tx(sbp_pkg::SPD_S100, 8'hfe);
    t_rx(8'h3a);
    i_iso = 1'b0;
    step(4);
    t_rx(8'hc3);
    i_iso = 1'b1;
    t_pd();
    stop_test();
  end
endmodule
